// File: hw/twb_ctrl.v
// two-wire serial bus interface: registers, gating and word engine
//
// Local design decision: strobed register access.
`timescale 1ns/1ps
`include "twb_regs.vh"

module twb_ctrl (
  input  wire        clk_i,
  input  wire        reset_i,
  input  wire [11:0] addr_i,
  input  wire [7:0]  wdata_i,
  input  wire        wr_i,
  input  wire        rd_i,
  output reg  [7:0]  rdata_o,
  input  wire        lp_switch_i,
  input  wire        scl_i,
  input  wire        sda_i,
  output reg         scl_o,
  output reg         scl_oe_o,
  output reg         sda_o,
  output reg         sda_oe_o,
  output reg         irq_o
);

  // ================================================================
  // states
  localparam [2:0] S_IDLE  = 3'd0;
  localparam [2:0] S_WORD  = 3'd1;
  localparam [2:0] S_HOLD  = 3'd2;
  localparam [2:0] S_STOP  = 3'd3;
  localparam [2:0] S_SKIP  = 3'd4;
  localparam [2:0] S_START = 3'd5;

  // ================================================================
  // storage
  reg  [7:0]  gate;
  reg  [2:0]  bc;
  reg         ack_md;
  reg         address_detect_disable;
  reg  [2:0]  sck;
  reg         mode;
  reg  [1:0]  soft_reset_cmd_q;
  reg         master_select;
  reg         transmitter_select;
  reg         bb;
  reg         pin;
  reg         al;
  reg         addressed_as_slave;
  reg         ad0;
  reg         last_received_bit;
  reg  [6:0]  sa;
  reg         addressing_format_select;
  reg  [7:0]  txd;
  reg  [7:0]  rxd;
  reg  [7:0]  shreg;
  reg  [3:0]  bitcnt;
  reg         addr_ph;
  reg  [2:0]  st;
  reg  [10:0] tmr;
  reg         scl_lo;
  reg  [2:0]  scl_s;
  reg  [2:0]  sda_s;
  reg         scl_q;
  reg         sda_q;

  // ================================================================
  // decode
  wire        en        = gate[`TWB_GATE_EN_BIT];
  wire        wr_c1     = wr_i && addr_i == `TWB_ADDR_CTL_ONE;
  wire        wr_c2     = wr_i && addr_i == `TWB_ADDR_CTL_TWO;
  wire        wr_own    = wr_i && addr_i == `TWB_ADDR_OWN;
  wire        wr_dat    = wr_i && addr_i == `TWB_ADDR_DATA;
  wire [7:0]  status    = {master_select, transmitter_select, bb, pin, al, addressed_as_slave, ad0, last_received_bit};
  wire        soft_reset_cmd_now = wr_c2 && mode && soft_reset_cmd_q == `TWB_SOFT_RESET_CMD_ARM &&
                          wdata_i[`TWB_C2_SOFT_RESET_CMD_HI:`TWB_C2_SOFT_RESET_CMD_LO] == `TWB_SOFT_RESET_CMD_FIRE;
  // sampled bus levels agree on two stages before counting
  wire        scl_new   = (scl_s[1] == scl_s[2]) ? scl_s[2] : scl_q;
  wire        sda_new   = (sda_s[1] == sda_s[2]) ? sda_s[2] : sda_q;
  wire        scl_rise  = !scl_q && scl_new;
  wire        scl_fall  = scl_q && !scl_new;
  wire        start_det = scl_q && scl_new && sda_q && !sda_new;
  wire        stop_det  = scl_q && scl_new && !sda_q && sda_new;
  // ack clock only in ack mode
  wire [3:0]  nbits     = (bc == 3'd0) ? `TWB_BC_FULL : {1'b0, bc};
  wire [3:0]  nclk      = nbits + {3'd0, ack_md};
  wire [10:0] t_high    = (`TWB_THIGH_BASE << sck) + `TWB_THIGH_OFS;
  wire [10:0] t_low     = t_high + `TWB_TLOW_EXTRA;
  // address match or general call, disabled by the detect bit
  wire        gcall     = shreg == `TWB_GCALL;
  wire        hit       = (shreg[7:1] == sa && !addressing_format_select) || gcall;
  wire        match     = !address_detect_disable && hit;
  wire        sender    = master_select ? (addr_ph || transmitter_select) : (addressed_as_slave && transmitter_select && !addr_ph);
  wire        slv_xfer  = !master_select && addressed_as_slave && (st == S_WORD || st == S_HOLD);

  // ================================================================
  // registers and engine
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      rdata_o  <= 8'h00;
      scl_o    <= 1'b0;
      scl_oe_o <= 1'b0;
      sda_o    <= 1'b0;
      sda_oe_o <= 1'b0;
      irq_o    <= 1'b0;
      gate     <= `TWB_GATE_RST;
      bc       <= 3'd0;
      ack_md   <= 1'b0;
      address_detect_disable    <= 1'b0;
      sck      <= 3'd0;
      mode     <= 1'b0;
      soft_reset_cmd_q  <= 2'd0;
      master_select      <= 1'b0;
      transmitter_select      <= 1'b0;
      bb       <= 1'b0;
      pin      <= 1'b1;
      al       <= 1'b0;
      addressed_as_slave      <= 1'b0;
      ad0      <= 1'b0;
      last_received_bit      <= 1'b0;
      sa       <= 7'd0;
      addressing_format_select      <= 1'b0;
      txd      <= `TWB_DATA_RST;
      rxd      <= `TWB_DATA_RST;
      shreg    <= 8'h00;
      bitcnt   <= 4'd0;
      addr_ph  <= 1'b0;
      st       <= S_IDLE;
      tmr      <= 11'd0;
      scl_lo   <= 1'b0;
      scl_s    <= 3'b111;
      sda_s    <= 3'b111;
      scl_q    <= 1'b1;
      sda_q    <= 1'b1;
    end else begin
      irq_o <= 1'b0;
      scl_s <= {scl_s[1:0], scl_i};
      sda_s <= {sda_s[1:0], sda_i};
      scl_q <= scl_new;
      sda_q <= sda_new;
      // status read at shared address; control two never read back
      case (addr_i)
        `TWB_ADDR_GATE:    rdata_o <= rd_i ? gate : 8'h00;
        `TWB_ADDR_CTL_ONE: rdata_o <= rd_i ? {bc, ack_md, address_detect_disable, sck} : 8'h00;
        `TWB_ADDR_STATUS:  rdata_o <= rd_i ? status : 8'h00;
        `TWB_ADDR_OWN:     rdata_o <= rd_i ? {sa, addressing_format_select} : 8'h00;
        // read side returns received byte only
        `TWB_ADDR_DATA:    rdata_o <= rd_i ? rxd : 8'h00;
        default:           rdata_o <= 8'h00;
      endcase
      if (wr_i && addr_i == `TWB_ADDR_GATE) begin
        gate <= wdata_i;
      end
      // low-power switch clears control one, address and buffer
      if (lp_switch_i) begin
        bc       <= 3'd0;
        ack_md   <= 1'b0;
        address_detect_disable    <= 1'b0;
        sck      <= 3'd0;
        sa       <= 7'd0;
        addressing_format_select      <= 1'b0;
        txd      <= `TWB_DATA_RST;
        rxd      <= `TWB_DATA_RST;
        master_select      <= 1'b0;
        transmitter_select      <= 1'b0;
        pin      <= 1'b1;
        soft_reset_cmd_q  <= 2'd0;
        st       <= S_IDLE;
        scl_oe_o <= 1'b0;
        sda_oe_o <= 1'b0;
      // everything below needs the gate; stopped otherwise
      end else if (en) begin
        if (wr_c1) begin
          bc     <= wdata_i[`TWB_C1_BC_HI:`TWB_C1_BC_LO];
          ack_md <= wdata_i[`TWB_C1_ACK_BIT];
          sck    <= wdata_i[`TWB_C1_SCK_HI:`TWB_C1_SCK_LO];
          // cannot clear detect bit mid slave transfer
          if (!(slv_xfer && !wdata_i[`TWB_C1_ADDRESS_DETECT_DISABLE_BIT])) begin
            address_detect_disable <= wdata_i[`TWB_C1_ADDRESS_DETECT_DISABLE_BIT];
          end
        end
        if (wr_own) begin
          sa  <= wdata_i[7:1];
          addressing_format_select <= wdata_i[0];
        end
        // buffer write releases the pending word
        if (wr_dat) begin
          txd <= wdata_i;
          pin <= 1'b1;
        end
        if (wr_c2) begin
          mode <= wdata_i[`TWB_C2_MODE_BIT];
          // other bits only land with mode set
          if (mode) begin
            soft_reset_cmd_q <= wdata_i[`TWB_C2_SOFT_RESET_CMD_HI:`TWB_C2_SOFT_RESET_CMD_LO];
            if (wdata_i[`TWB_C2_PIN_BIT]) begin
              pin <= 1'b1;
            end
            if (wdata_i[`TWB_C2_MST_BIT] && wdata_i[`TWB_C2_BB_BIT] && !bb) begin
              master_select      <= 1'b1;
              transmitter_select      <= 1'b1;
              st       <= S_START;
              sda_oe_o <= 1'b1;
            end else if (wdata_i[`TWB_C2_MST_BIT] && !wdata_i[`TWB_C2_BB_BIT] &&
                         master_select && bb && st == S_HOLD) begin
              st       <= S_STOP;
              scl_lo   <= 1'b1;
              sda_oe_o <= 1'b1;
              scl_oe_o <= 1'b1;
              tmr      <= t_low;
            end else begin
              master_select <= wdata_i[`TWB_C2_MST_BIT];
              transmitter_select <= wdata_i[`TWB_C2_TRX_BIT];
            end
          end
          if (!wdata_i[`TWB_C2_MODE_BIT]) begin
            master_select      <= 1'b0;
            transmitter_select      <= 1'b0;
            bb       <= 1'b0;
            pin      <= 1'b1;
            al       <= 1'b0;
            addressed_as_slave      <= 1'b0;
            ad0      <= 1'b0;
            last_received_bit      <= 1'b0;
            st       <= S_IDLE;
            scl_oe_o <= 1'b0;
            sda_oe_o <= 1'b0;
          end
        end
        // two-step soft reset, mode bit kept
        if (soft_reset_cmd_now) begin
          bc       <= 3'd0;
          ack_md   <= 1'b0;
          address_detect_disable    <= 1'b0;
          sck      <= 3'd0;
          sa       <= 7'd0;
          addressing_format_select      <= 1'b0;
          master_select      <= 1'b0;
          transmitter_select      <= 1'b0;
          bb       <= 1'b0;
          pin      <= 1'b1;
          al       <= 1'b0;
          addressed_as_slave      <= 1'b0;
          ad0      <= 1'b0;
          last_received_bit      <= 1'b0;
          soft_reset_cmd_q  <= 2'd0;
          st       <= S_IDLE;
          scl_oe_o <= 1'b0;
          sda_oe_o <= 1'b0;
        end else if (mode) begin
          // engine runs after register writes so its flag sets win
          if (start_det) begin
            bb      <= 1'b1;
            bc      <= `TWB_BC_START;
            st      <= S_WORD;
            bitcnt  <= 4'd0;
            addr_ph <= 1'b1;
            shreg   <= master_select ? txd : 8'h00;
            addressed_as_slave     <= 1'b0;
            ad0     <= 1'b0;
            scl_lo  <= 1'b0;
            tmr     <= t_high;
          end else if (stop_det) begin
            bb       <= 1'b0;
            st       <= S_IDLE;
            scl_oe_o <= 1'b0;
            sda_oe_o <= 1'b0;
          end else begin
            case (st)
              S_WORD: begin
                // master clocking; a slave only follows the pin
                if (master_select && (scl_lo || scl_q)) begin
                  if (tmr == 11'd0) begin
                    scl_lo   <= !scl_lo;
                    scl_oe_o <= !scl_lo;
                    tmr      <= scl_lo ? t_high : t_low;
                  end else begin
                    tmr <= tmr - 11'd1;
                  end
                end
                if (scl_rise) begin
                  bitcnt <= bitcnt + 4'd1;
                  if (bitcnt < nbits) begin
                    shreg <= {shreg[6:0], sda_q};
                    if (master_select && sender && shreg[7] && !sda_q) begin
                      al       <= 1'b1;
                      master_select      <= 1'b0;
                      sda_oe_o <= 1'b0;
                      scl_oe_o <= 1'b0;
                    end
                  end else begin
                    last_received_bit <= sda_q;
                  end
                end
                if (scl_fall) begin
                  // ignored address: no ack, no interrupt
                  if (!master_select && addr_ph && bitcnt == nbits && !match) begin
                    st       <= S_SKIP;
                    sda_oe_o <= 1'b0;
                  // word finished: request and hold clock low
                  end else if (bitcnt == nclk) begin
                    st       <= S_HOLD;
                    pin      <= 1'b0;
                    irq_o    <= 1'b1;
                    rxd      <= shreg;
                    addr_ph  <= 1'b0;
                    sda_oe_o <= 1'b0;
                    scl_oe_o <= 1'b1;
                    if (master_select && addr_ph) begin
                      transmitter_select <= !txd[0];
                    end
                    // detect bit plays no part for a master
                    if (!master_select && addr_ph) begin
                      addressed_as_slave <= 1'b1;
                      ad0 <= gcall;
                      transmitter_select <= shreg[0];
                    end
                  end else if (bitcnt == nbits) begin
                    sda_oe_o <= master_select ? !transmitter_select : (addr_ph || !transmitter_select);
                    if (!master_select && addr_ph) begin
                      addressed_as_slave <= 1'b1;
                      ad0 <= gcall;
                      transmitter_select <= shreg[0];
                    end
                  end else begin
                    sda_oe_o <= sender && !shreg[7];
                  end
                end
              end
              S_HOLD: begin
                // new word uses the current bit count
                if (pin) begin
                  st       <= S_WORD;
                  bitcnt   <= 4'd0;
                  shreg    <= txd;
                  sda_oe_o <= sender && !txd[7];
                  scl_lo   <= master_select;
                  scl_oe_o <= master_select;
                  tmr      <= t_low;
                end
              end
              S_STOP: begin
                if (tmr != 11'd0) begin
                  tmr <= tmr - 11'd1;
                end else if (scl_lo) begin
                  scl_lo   <= 1'b0;
                  scl_oe_o <= 1'b0;
                  tmr      <= t_high;
                end else if (scl_q) begin
                  sda_oe_o <= 1'b0;
                  master_select      <= 1'b0;
                end
              end
              S_START: begin
                // sda held low with scl free until start is seen
                sda_oe_o <= 1'b1;
              end
              S_SKIP: begin
                sda_oe_o <= 1'b0;
              end
              default: begin
                st <= S_IDLE;
              end
            endcase
          end
        end
      end
    end
  end

endmodule // twb_ctrl

// File: shared/twb_regs.vh
// register map, field positions, reset values and timing counts of the two-wire block
`ifndef TWB_REGS_VH
`define TWB_REGS_VH

// ================================================================
// register addresses
`define TWB_ADDR_GATE     12'h0F75
`define TWB_ADDR_CTL_ONE  12'h0022
`define TWB_ADDR_CTL_TWO  12'h0023
`define TWB_ADDR_STATUS   12'h0023
`define TWB_ADDR_OWN      12'h0024
`define TWB_ADDR_DATA     12'h0025

// ================================================================
// field positions
`define TWB_GATE_EN_BIT   4
`define TWB_C1_BC_HI      7
`define TWB_C1_BC_LO      5
`define TWB_C1_ACK_BIT    4
`define TWB_C1_ADDRESS_DETECT_DISABLE_BIT  3
`define TWB_C1_SCK_HI     2
`define TWB_C1_SCK_LO     0
`define TWB_C2_MST_BIT    7
`define TWB_C2_TRX_BIT    6
`define TWB_C2_BB_BIT     5
`define TWB_C2_PIN_BIT    4
`define TWB_C2_MODE_BIT   3
`define TWB_C2_SOFT_RESET_CMD_HI   1
`define TWB_C2_SOFT_RESET_CMD_LO   0

// ================================================================
// reset values and codes
`define TWB_GATE_RST      8'h00
`define TWB_C1_RST        8'h00
`define TWB_OWN_RST       8'h00
`define TWB_DATA_RST      8'h00
`define TWB_BC_START      3'h0
`define TWB_BC_FULL       4'h8
`define TWB_GCALL         8'h00
`define TWB_SOFT_RESET_CMD_ARM     2'h2
`define TWB_SOFT_RESET_CMD_FIRE    2'h1

// ================================================================
// serial clock timing in gear-clock cycles: high = (base << sck) + offset
`define TWB_THIGH_BASE    11'h002
`define TWB_THIGH_OFS     11'h007
`define TWB_TLOW_EXTRA    11'h003

`endif

// File: tb/twb_bus_master.sv
// behavioural bus master on the far side of the two-wire block
`timescale 1ns/1ps
module twb_bus_master #(
  parameter int HALF = 10
) (
  input  wire clk_i,
  input  wire scl_i,
  input  wire sda_i,
  output reg  scl_oe_o,
  output reg  sda_oe_o
);
  int stall_err = 0;
  initial begin
    scl_oe_o = 1'b0;
    sda_oe_o = 1'b0;
  end
  task automatic gap();
    repeat (HALF) @(posedge clk_i);
  endtask
  // slave may stretch the clock, so wait on the wire
  task automatic rise();
    int n;
    n = 0;
    scl_oe_o <= 1'b0;
    @(posedge clk_i);
    while (!scl_i && n < 2000) begin
      @(posedge clk_i);
      n++;
    end
    if (!scl_i) stall_err++;
    gap();
  endtask
  task automatic wait_scl(input logic lvl);
    int n;
    n = 0;
    while (scl_i !== lvl && n < 2000) begin
      @(posedge clk_i);
      n++;
    end
    if (scl_i !== lvl) stall_err++;
  endtask
  // far-side receiver: take bits, ack low
  task automatic listen(input int nb, output logic [7:0] d);
    d = 8'h00;
    for (int i = 0; i < nb; i++) begin
      wait_scl(1'b0);
      wait_scl(1'b1);
      d = {d[6:0], sda_i};
    end
    wait_scl(1'b0);
    sda_oe_o <= 1'b1;
    wait_scl(1'b1);
    wait_scl(1'b0);
    sda_oe_o <= 1'b0;
  endtask
  task automatic start();
    sda_oe_o <= 1'b0;
    rise();
    sda_oe_o <= 1'b1;
    gap();
    scl_oe_o <= 1'b1;
    gap();
  endtask
  task automatic stop();
    sda_oe_o <= 1'b1;
    gap();
    rise();
    sda_oe_o <= 1'b0;
    gap();
  endtask
  task automatic word(input logic [7:0] d, input int nb, input bit ack_clk, output logic ack);
    ack = 1'b1;
    for (int i = nb - 1; i >= 0; i--) begin
      sda_oe_o <= ~d[i];
      gap();
      rise();
      scl_oe_o <= 1'b1;
      gap();
    end
    if (ack_clk) begin
      sda_oe_o <= 1'b0;
      gap();
      rise();
      ack = sda_i;
      scl_oe_o <= 1'b1;
      gap();
    end
  endtask
endmodule // twb_bus_master

// File: tb/twb_ctrl_properties.sv
// assertion checker for the two-wire control block
`timescale 1ns/1ps
module twb_ctrl_properties (
  input wire        clk_i,
  input wire        reset_i,
  input wire [11:0] addr_i,
  input wire [7:0]  wdata_i,
  input wire        wr_i,
  input wire        rd_i,
  input wire [7:0]  rdata_o,
  input wire        lp_switch_i,
  input wire        scl_i,
  input wire        sda_i,
  input wire        scl_o,
  input wire        scl_oe_o,
  input wire        sda_o,
  input wire        sda_oe_o,
  input wire        irq_o
);
  // ==========
  // shadow of gate, mode and master bits
  reg  gate_on;
  reg  mode_on;
  reg  mst_on;
  wire mapped = (addr_i == 12'h0F75) || (addr_i >= 12'h0022 && addr_i <= 12'h0025);
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      gate_on <= 1'b0;
      mode_on <= 1'b0;
      mst_on  <= 1'b0;
    end else if (wr_i) begin
      if (addr_i == 12'h0F75) gate_on <= wdata_i[4];
      if (addr_i == 12'h0023 && gate_on) mode_on <= wdata_i[3];
      // own start and stop move data with the clock high
      if (addr_i == 12'h0023 && gate_on && mode_on) mst_on <= wdata_i[7];
    end
  end
  // ==========
  // properties
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);
  AST_RDATA_IDLE: assert property (!rd_i |=> rdata_o == 8'h00)
    else $error("read data outside answer cycle");
  AST_RD_UNMAPPED: assert property (rd_i && !mapped |=> rdata_o == 8'h00)
    else $error("unmapped read not zero");
  AST_IRQ_PULSE: assert property (irq_o |=> !irq_o)
    else $error("irq longer than one cycle");
  AST_IRQ_HOLD: assert property (irq_o |-> ##[0:2] scl_oe_o)
    else $error("clock not held after word");
  AST_OD_ZERO: assert property (scl_o == 1'b0 && sda_o == 1'b0)
    else $error("open drain value not low");
  AST_GATE_QUIET: assert property (!gate_on |-> !irq_o && !sda_oe_o && !scl_oe_o)
    else $error("activity while gated");
  AST_STATUS_IDLE: assert property (rd_i && addr_i == 12'h0023 && !mode_on
    |=> rdata_o[7:1] == 7'h08)
    else $error("status not at reset value");
  AST_SDA_SCL_LOW: assert property ($changed(sda_oe_o) && !mst_on |-> !scl_i)
    else $error("data pin moved while clock high");
endmodule // twb_ctrl_properties

bind twb_ctrl twb_ctrl_properties twb_ctrl_properties_inst (
  .clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
  .rd_i(rd_i), .rdata_o(rdata_o), .lp_switch_i(lp_switch_i), .scl_i(scl_i), .sda_i(sda_i),
  .scl_o(scl_o), .scl_oe_o(scl_oe_o), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .irq_o(irq_o));

// File: tb/two_wire_bus_iface_control_tb_top.sv
// self-checking bench of the two-wire control block
`timescale 1ns/1ps
module two_wire_bus_iface_control_tb_top;
  reg         clk_i = 1'b0;
  reg         reset_i = 1'b1;
  reg  [11:0] addr_i = 12'h000;
  reg  [7:0]  wdata_i = 8'h00;
  reg         wr_i = 1'b0;
  reg         rd_i = 1'b0;
  reg         lp_switch_i = 1'b0;
  wire [7:0]  rdata_o;
  wire        scl_o, scl_oe_o, sda_o, sda_oe_o, irq_o, m_scl_oe, m_sda_oe;
  // pull-ups on both lines
  wire        scl_w = ~(scl_oe_o | m_scl_oe);
  wire        sda_w = ~(sda_oe_o | m_sda_oe);
  int         miscompares = 0;
  int         cmp_count = 0;
  int         irqs = 0;
  int         mreg[int];
  logic       ack;
  logic [7:0] v;
  always #10 clk_i = ~clk_i;
  always @(posedge clk_i) if (irq_o === 1'b1) irqs++;
  twb_ctrl twb_ctrl_inst (.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .lp_switch_i(lp_switch_i), .scl_i(scl_w),
    .sda_i(sda_w), .scl_o(scl_o), .scl_oe_o(scl_oe_o), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
    .irq_o(irq_o));
  twb_bus_master twb_bus_master_inst (.clk_i(clk_i), .scl_i(scl_w), .sda_i(sda_w),
    .scl_oe_o(m_scl_oe), .sda_oe_o(m_sda_oe));
  // ==========
  // bus tasks and model
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] msk);
    cmp_count++;
    if ((got & msk) !== (exp & msk)) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // model keeps readable registers; data buffer reads never echo writes
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    if (a == 12'h0F75 || (mreg[12'h0F75][4] && mreg.exists(a))) mreg[a] = d;
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e, input logic [7:0] msk);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(negedge clk_i);
    chk(rdata_o, e, msk);
  endtask
  task automatic rm(input logic [11:0] a);
    rd(a, mreg[a][7:0], 8'hFF);
  endtask
  task automatic slave_word(input logic [7:0] d, input int nb, input bit ac, input logic ea,
                            input int ei);
    twb_bus_master_inst.word(d, nb, ac, ack);
    chk({7'h00, ack}, {7'h00, ea}, 8'hFF);
    chk(8'(irqs), 8'(ei), 8'hFF);
  endtask
  task automatic close_out();
    miscompares += twb_bus_master_inst.stall_err;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge clk_i);
    miscompares++;
    close_out();
  end
  // ==========
  // scenarios
  initial begin
    void'($urandom(32'h58f8_2755));
    mreg[12'h0F75] = 0;
    mreg[12'h0022] = 0;
    mreg[12'h0024] = 0;
    repeat (4) @(posedge clk_i);
    reset_i <= 1'b0;
    rd(12'h0023, 8'h10, 8'hFE);
    rd(12'h0025, 8'h00, 8'hFF);
    rd(12'h0100, 8'h00, 8'hFF);
    wr(12'h0022, 8'hFF);
    rm(12'h0022);
    wr(12'h0F75, 8'h10);
    rm(12'h0F75);
    wr(12'h0023, 8'hF0);
    rd(12'h0023, 8'h10, 8'hFE);
    wr(12'h0023, 8'h18);
    rd(12'h0023, 8'h10, 8'hFE);
    for (int i = 0; i < 3; i++) begin
      v = 8'($urandom);
      wr(12'h0022, v);
      rm(12'h0022);
      wr(12'h0024, v | 8'h02);
      rm(12'h0024);
      wr(12'h0025, v | 8'h01);
      rd(12'h0025, 8'h00, 8'hFF);
    end
    wr(12'h0023, 8'h1A);
    wr(12'h0023, 8'h19);
    mreg[12'h0022] = 0;
    mreg[12'h0024] = 0;
    rm(12'h0022);
    rm(12'h0024);
    rd(12'h0023, 8'h10, 8'hFE);
    // three-bit count must not shorten the address word
    wr(12'h0022, 8'h70);
    wr(12'h0024, 8'hA0);
    twb_bus_master_inst.start();
    slave_word(8'hA0, 8, 1, 1'b0, 1);
    rd(12'h0023, 8'h24, 8'hFE);
    // start cleared the count, so set it again
    wr(12'h0022, 8'h70);
    wr(12'h0025, 8'h00);
    slave_word(8'h05, 3, 1, 1'b0, 2);
    rd(12'h0025, 8'h05, 8'h07);
    wr(12'h0022, 8'h00);
    wr(12'h0025, 8'h00);
    slave_word(8'hC3, 8, 0, 1'b1, 3);
    rd(12'h0025, 8'hC3, 8'hFF);
    wr(12'h0025, 8'h00);
    twb_bus_master_inst.stop();
    rd(12'h0023, 8'h00, 8'h20);
    wr(12'h0022, 8'h5C);
    @(posedge clk_i);
    lp_switch_i <= 1'b1;
    @(posedge clk_i);
    lp_switch_i <= 1'b0;
    mreg[12'h0022] = 0;
    mreg[12'h0024] = 0;
    rm(12'h0022);
    rm(12'h0024);
    rd(12'h0025, 8'h00, 8'hFF);
    wr(12'h0024, 8'hA0);
    wr(12'h0022, 8'h18);
    twb_bus_master_inst.start();
    slave_word(8'hA0, 8, 1, 1'b1, 3);
    twb_bus_master_inst.stop();
    wr(12'h0022, 8'h10);
    twb_bus_master_inst.start();
    slave_word(8'h00, 8, 1, 1'b0, 4);
    rd(12'h0023, 8'h02, 8'h02);
    wr(12'h0023, 8'h18);
    twb_bus_master_inst.stop();
    // master side: address out, far side acks, then stop
    // clock code 0 at 50MHz
    wr(12'h0022, 8'h18);
    wr(12'h0025, 8'hA0);
    wr(12'h0023, 8'hF8);
    twb_bus_master_inst.listen(8, v);
    repeat (8) @(posedge clk_i);
    chk(v, 8'hA0, 8'hFF);
    chk(8'(irqs), 8'd5, 8'hFF);
    rd(12'h0023, 8'hE0, 8'hFF);
    wr(12'h0023, 8'hD8);
    repeat (60) @(posedge clk_i);
    rd(12'h0023, 8'h10, 8'hB0);
    close_out();
  end
endmodule // two_wire_bus_iface_control_tb_top
